// ---- src/sssm_pkg.sv ----
// Shared constants, status codes and helpers of the SPI script and stream master.
package sssm_pkg;

  // Clock and microsecond timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int DELAY_UNIT_NS = 1000;
  localparam int US_CYCLES = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] US_LAST = 6'(US_CYCLES - 1);

  // Script command operation codes.
  localparam logic [2:0] OP_END = 3'h0;
  localparam logic [2:0] OP_DELAY = 3'h1;
  localparam logic [2:0] OP_WIDTH = 3'h2;
  localparam logic [2:0] OP_XCHG = 3'h3;
  localparam logic [2:0] OP_DATA = 3'h4;
  localparam logic [2:0] OP_ENABLE = 3'h5;

  // Status codes, two's complement: zero ok, negative error, positive warning.
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_WARN_PARTIAL = 8'h01;
  localparam logic [7:0] STAT_ERR_PORT = 8'hff;
  localparam logic [7:0] STAT_ERR_ZERO = 8'hfe;
  localparam logic [7:0] STAT_ERR_BUSY = 8'hfd;
  localparam logic [7:0] STAT_ERR_OP = 8'hfc;

  // Sample width limits and values after reset.
  localparam logic [4:0] WIDTH_MIN = 5'h01;
  localparam logic [4:0] WIDTH_MAX = 5'h10;
  localparam logic [4:0] WIDTH_RST = 5'h08;
  localparam logic [7:0] SLOT_RST = 8'h00;
  localparam int BUF_DEPTH = 2;
  localparam int SCLK_HALF = 2;

  // Whole bytes needed to hold one sample of the given width.
  function automatic logic [1:0] sssm_bps(input logic [4:0] width);
    sssm_bps = (width > 5'h08) ? 2'h2 : 2'h1;
  endfunction : sssm_bps

  // Keeps a requested width inside the supported range.
  function automatic logic [4:0] sssm_clamp(input logic [4:0] width);
    if (width < WIDTH_MIN)
    begin
      sssm_clamp = WIDTH_MIN;
    end
    else if (width > WIDTH_MAX)
    begin
      sssm_clamp = WIDTH_MAX;
    end
    else
    begin
      sssm_clamp = width;
    end
  endfunction : sssm_clamp

endpackage : sssm_pkg

// ---- src/sssm_fifo.sv ----
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/10ps
module sssm_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  // DEPTH must be a power of two so that the pointers wrap by themselves.
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : sssm_fifo

// ---- src/sssm_master.sv ----
// SPI script and stream master: script executor, streamer and link shifter.
// Notes on behaviour
// - Single-port adapter accepts only port index zero.
// - Run loads script, executes, then reports status.
// - Delay holds next command given microseconds.
// - Exchange captures exactly as much as sent.
// - Captured data tagged with its exchange index.
// - Samples big endian, fewest bytes, zero padded.
// - Twelve-bit samples use two bytes, top ignored.
// - Partial trailing sample dropped, warning raised.
// - Streaming drives configured SPI and aux waveform.
// - Stream start enters streaming mode, starts waveform.
// - Full undrained buffer pauses stream transfers.
// - Buffering stops at sample count or stop.
// - Stream stop ends waveform, returns normal mode.
// - Every operation reports zero, negative or positive.
// - Sample width holds until script ends or changes.
// - Enable drives pins, chip select driven high.
// - Stream timings counted in system clock cycles.
`timescale 1ns/10ps
module sssm_master #(
  parameter int NUM_PORTS = 1,
  parameter int HALF_CYCLES = sssm_pkg::SCLK_HALF
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  input wire logic run_i,
  input wire logic [7:0] port_index_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [2:0] cmd_op_i,
  input wire logic [15:0] cmd_arg_i,
  output logic status_valid_o,
  output logic [7:0] status_o,
  input wire logic stream_start_i,
  input wire logic stream_stop_i,
  input wire logic [31:0] stream_count_i,
  input wire logic [4:0] stream_width_i,
  input wire logic [15:0] stream_conv_cycles_i,
  input wire logic [15:0] stream_gap_cycles_i,
  output logic streaming_o,
  output logic cap_valid_o,
  input wire logic cap_ready_i,
  output logic [15:0] cap_data_o,
  output logic [7:0] cap_slot_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic cs_oe_o,
  output logic aux_out_o,
  output logic aux_oe_o
);
  import sssm_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_DELAY, ST_XDATA, ST_XWAIT, ST_XPUSH, ST_DONE,
    ST_CONV, ST_SWAIT, ST_SPUSH, ST_GAP, ST_HOLD, ST_SSTOP
  } sssm_state_e;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  sssm_state_e state;
  logic port_err;
  logic zero_err;
  logic op_err;
  logic warn;
  logic pins_en;
  logic [7:0] slot;
  logic [4:0] width;
  logic [15:0] remain;
  logic bcnt;
  logic [7:0] asm_hi;
  logic [15:0] us_left;
  logic [5:0] pre;
  logic [15:0] cnt;
  logic [31:0] scount;
  logic [31:0] starget;
  logic stop_pend;
  logic cs_n;
  logic aux;
  logic streaming;
  logic status_valid;
  logic [7:0] status;
  logic job_req;
  logic [15:0] job_tx;
  logic [4:0] job_width;
  logic ack_s1;
  logic ack_s2;
  logic ack_s3;

  // Link-domain state.
  logic lrst_s1;
  logic lrstn;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic miso_s1;
  logic miso_s2;
  logic l_busy;
  logic [7:0] l_half;
  logic [4:0] l_bits;
  logic [15:0] l_tx;
  logic [15:0] l_rx;
  logic l_sclk;
  logic l_ack;

  logic fifo_in_ready;

  wire cmd_fire = cmd_valid_i & cmd_ready_o;
  wire [7:0] cmd_byte = cmd_arg_i[7:0];
  wire [1:0] bps = sssm_bps(width);
  wire sample_full = bcnt | (bps == 2'h1);
  wire [15:0] asm_word = (bps == 2'h2) ? {asm_hi, cmd_byte} : {8'h00, cmd_byte};
  wire ack_pulse = ack_s2 ^ ack_s3;
  wire push_valid = (state == ST_XPUSH) | (state == ST_SPUSH);
  wire push_fire = push_valid & fifo_in_ready;
  wire port_ok = (port_index_i < 8'(NUM_PORTS));
  wire last_sample = ((scount + 32'h1) == starget);
  wire [7:0] end_status = port_err ? STAT_ERR_PORT :
                          op_err ? STAT_ERR_OP :
                          zero_err ? STAT_ERR_ZERO :
                          warn ? STAT_WARN_PARTIAL : STAT_OK;
  wire l_start = (req_s2 ^ req_s3) & ~l_busy;
  wire [4:0] l_shift = WIDTH_MAX - job_width;

  // Commands are only accepted while nothing else is in flight.
  assign cmd_ready_o = (state == ST_CMD) | (state == ST_XDATA);
  assign status_valid_o = status_valid;
  assign status_o = status;
  assign streaming_o = streaming;
  assign cs_n_o = cs_n;
  assign cs_oe_o = pins_en;
  assign sclk_oe_o = pins_en;
  assign mosi_oe_o = pins_en;
  assign sclk_o = l_sclk;
  assign mosi_o = l_tx[15];
  assign aux_out_o = aux;
  assign aux_oe_o = streaming;

  // Event and word crossing back from the link: ack toggle then stable data.
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end
    else
    begin
      ack_s1 <= l_ack;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  // Stop requests are remembered so a transfer in flight completes cleanly.
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      stop_pend <= 1'b0;
    end
    else if (streaming && stream_stop_i)
    begin
      stop_pend <= 1'b1;
    end
    else if (!streaming)
    begin
      // A stop seen in the last streaming cycle must not stop the next stream.
      stop_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      port_err <= 1'b0;
      zero_err <= 1'b0;
      op_err <= 1'b0;
      warn <= 1'b0;
      pins_en <= 1'b0;
      slot <= SLOT_RST;
      width <= WIDTH_RST;
      remain <= 16'h0000;
      bcnt <= 1'b0;
      asm_hi <= 8'h00;
      us_left <= 16'h0000;
      pre <= 6'h00;
      cnt <= 16'h0000;
      scount <= 32'h0;
      starget <= 32'h0;
      cs_n <= 1'b1;
      aux <= 1'b0;
      streaming <= 1'b0;
      status_valid <= 1'b0;
      status <= STAT_OK;
      job_req <= 1'b0;
      job_tx <= 16'h0000;
      job_width <= WIDTH_RST;
    end
    else
    begin
      status_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (run_i)
          begin
            port_err <= ~port_ok;
            zero_err <= 1'b0;
            op_err <= 1'b0;
            warn <= 1'b0;
            slot <= SLOT_RST;
            width <= WIDTH_RST;
            state <= ST_CMD;
          end
          else if (stream_start_i)
          begin
            width <= sssm_clamp(stream_width_i);
            starget <= stream_count_i;
            scount <= 32'h0;
            cnt <= 16'h0000;
            streaming <= 1'b1;
            pins_en <= 1'b1;
            status <= STAT_OK;
            status_valid <= 1'b1;
            state <= (stream_count_i == 32'h0) ? ST_HOLD : ST_CONV;
          end
        end
        ST_CMD:
        begin
          if (cmd_fire)
          begin
            if (cmd_op_i == OP_END)
            begin
              state <= ST_DONE;
            end
            else if (port_err)
            begin
              // A script aimed at a missing port is drained without effect.
              state <= ST_CMD;
            end
            else if (cmd_op_i == OP_DELAY)
            begin
              us_left <= cmd_arg_i;
              pre <= 6'h00;
              state <= ST_DELAY;
            end
            else if (cmd_op_i == OP_WIDTH)
            begin
              width <= sssm_clamp(cmd_arg_i[4:0]);
            end
            else if (cmd_op_i == OP_ENABLE)
            begin
              pins_en <= 1'b1;
            end
            else if (cmd_op_i == OP_XCHG)
            begin
              if (cmd_arg_i == 16'h0000)
              begin
                zero_err <= 1'b1;
              end
              else
              begin
                remain <= cmd_arg_i;
                bcnt <= 1'b0;
                cs_n <= 1'b0;
                state <= ST_XDATA;
              end
            end
            else
            begin
              op_err <= 1'b1;
            end
          end
        end
        ST_DELAY:
        begin
          if (us_left == 16'h0000)
          begin
            state <= ST_CMD;
          end
          else if (pre == US_LAST)
          begin
            pre <= 6'h00;
            us_left <= us_left - 16'h0001;
          end
          else
          begin
            pre <= pre + 6'h01;
          end
        end
        ST_XDATA:
        begin
          if (cmd_fire)
          begin
            remain <= remain - 16'h0001;
            if (sample_full)
            begin
              // Only the low width bits go out; the rest are ignored.
              job_tx <= asm_word;
              job_width <= width;
              job_req <= ~job_req;
              bcnt <= 1'b0;
              state <= ST_XWAIT;
            end
            else if (remain == 16'h0001)
            begin
              warn <= 1'b1;
              cs_n <= 1'b1;
              slot <= slot + 8'h01;
              state <= ST_CMD;
            end
            else
            begin
              asm_hi <= cmd_byte;
              bcnt <= 1'b1;
            end
          end
        end
        ST_XWAIT:
        begin
          if (ack_pulse)
          begin
            state <= ST_XPUSH;
          end
        end
        ST_XPUSH:
        begin
          // A full capture buffer stalls the script rather than losing data.
          if (push_fire)
          begin
            if (remain == 16'h0000)
            begin
              cs_n <= 1'b1;
              slot <= slot + 8'h01;
              state <= ST_CMD;
            end
            else
            begin
              state <= ST_XDATA;
            end
          end
        end
        ST_DONE:
        begin
          status <= end_status;
          status_valid <= 1'b1;
          width <= WIDTH_RST;
          state <= ST_IDLE;
        end
        ST_CONV:
        begin
          if (stop_pend)
          begin
            state <= ST_SSTOP;
          end
          else if (cnt == stream_conv_cycles_i)
          begin
            aux <= 1'b0;
            cs_n <= 1'b0;
            job_tx <= 16'h0000;
            job_width <= width;
            job_req <= ~job_req;
            state <= ST_SWAIT;
          end
          else
          begin
            aux <= 1'b1;
            cnt <= cnt + 16'h0001;
          end
        end
        ST_SWAIT:
        begin
          if (ack_pulse)
          begin
            state <= ST_SPUSH;
          end
        end
        ST_SPUSH:
        begin
          if (push_fire)
          begin
            cs_n <= 1'b1;
            cnt <= 16'h0000;
            scount <= scount + 32'h1;
            state <= last_sample ? ST_HOLD : ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (stop_pend)
          begin
            state <= ST_SSTOP;
          end
          else if (cnt == stream_gap_cycles_i)
          begin
            cnt <= 16'h0000;
            state <= ST_CONV;
          end
          else
          begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_HOLD:
        begin
          if (stop_pend)
          begin
            state <= ST_SSTOP;
          end
        end
        ST_SSTOP:
        begin
          streaming <= 1'b0;
          aux <= 1'b0;
          cs_n <= 1'b1;
          width <= WIDTH_RST;
          status <= STAT_OK;
          status_valid <= 1'b1;
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
      if (stream_start_i && state != ST_IDLE)
      begin
        status <= STAT_ERR_BUSY;
        status_valid <= 1'b1;
      end
    end
  end

  // The host drains this buffer on its own handshake, never the link.
  sssm_fifo #(
    .WIDTH(24),
    .DEPTH(BUF_DEPTH)
  ) u_capture_buf (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({slot, l_rx}),
    .out_valid_o(cap_valid_o),
    .out_ready_i(cap_ready_i),
    .out_data_o({cap_slot_o, cap_data_o})
  );

  // Reset, request toggle and serial input are brought into the link domain.
  always_ff @(posedge link_clk_i)
  begin
    lrst_s1 <= resetn_i;
    lrstn <= lrst_s1;
    req_s1 <= job_req;
    req_s2 <= req_s1;
    miso_s1 <= miso_i;
    miso_s2 <= miso_s1;
  end

  // Mode 0 shifter; the input is sampled at the end of the high phase so
  // that the two synchroniser stages still see the settled bit.
  always_ff @(posedge link_clk_i)
  begin
    if (!lrstn)
    begin
      req_s3 <= 1'b0;
      l_busy <= 1'b0;
      l_half <= 8'h00;
      l_bits <= 5'h00;
      l_tx <= 16'h0000;
      l_rx <= 16'h0000;
      l_sclk <= 1'b0;
      l_ack <= 1'b0;
    end
    else
    begin
      req_s3 <= req_s2;
      if (l_start)
      begin
        l_busy <= 1'b1;
        l_tx <= job_tx << l_shift;
        l_bits <= job_width;
        l_half <= 8'h00;
        l_sclk <= 1'b0;
        l_rx <= 16'h0000;
      end
      else if (l_busy)
      begin
        if (l_half != HALF_LAST)
        begin
          l_half <= l_half + 8'h01;
        end
        else if (!l_sclk)
        begin
          l_half <= 8'h00;
          l_sclk <= 1'b1;
        end
        else
        begin
          l_half <= 8'h00;
          l_sclk <= 1'b0;
          l_rx <= {l_rx[14:0], miso_s2};
          l_tx <= {l_tx[14:0], 1'b0};
          l_bits <= l_bits - 5'h01;
          if (l_bits == 5'h01)
          begin
            l_busy <= 1'b0;
            l_ack <= ~l_ack;
          end
        end
      end
    end
  end

endmodule : sssm_master

// ---- bench/sssm_master_monitor.sv ----
// Concurrent checks on the ports of the script and stream master.
`timescale 1ns/10ps
module sssm_master_monitor
  import sssm_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic [2:0] cmd_op_i,
  input wire logic [15:0] cmd_arg_i,
  input wire logic status_valid_o,
  input wire logic [7:0] status_o,
  input wire logic stream_start_i,
  input wire logic stream_stop_i,
  input wire logic streaming_o,
  input wire logic cap_valid_o,
  input wire logic cap_ready_i,
  input wire logic [15:0] cap_data_o,
  input wire logic [7:0] cap_slot_o,
  input wire logic cs_n_o,
  input wire logic cs_oe_o,
  input wire logic sclk_oe_o,
  input wire logic mosi_oe_o,
  input wire logic aux_out_o,
  input wire logic aux_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  wire cmd_take = cmd_valid_i && cmd_ready_o;
  property p_start;
    $rose(streaming_o) |-> $past(stream_start_i) && aux_oe_o && cs_oe_o;
  endproperty
  a_start: assert property (p_start) else $error("stream entry bad");
  property p_stop;
    $fell(streaming_o) |-> ##[0:1] (status_valid_o && status_o == STAT_OK);
  endproperty
  a_stop: assert property (p_stop) else $error("stop status bad");
  property p_stop_req;
    streaming_o && stream_stop_i |-> ##[1:400] !streaming_o;
  endproperty
  a_stop_req: assert property (p_stop_req)
    else $error("stop ignored");
  // The strobe itself may only pulse while the stream owns the pins.
  property p_aux_oe;
    (aux_oe_o == streaming_o) && (!aux_out_o || streaming_o);
  endproperty
  a_aux_oe: assert property (p_aux_oe) else $error("aux enable bad");
  property p_aux_cs;
    aux_out_o |-> cs_n_o;
  endproperty
  a_aux_cs: assert property (p_aux_cs)
    else $error("aux during frame");
  property p_cap_hold;
    cap_valid_o && !cap_ready_i |=>
      cap_valid_o && $stable(cap_data_o) && $stable(cap_slot_o);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("sample lost");
  property p_status_pulse;
    status_valid_o |=> !status_valid_o && $stable(status_o);
  endproperty
  a_status_pulse: assert property (p_status_pulse)
    else $error("status");
  property p_ready_delay;
    cmd_take && cmd_op_i == OP_DELAY && cmd_arg_i != 16'h0000 |=>
      !cmd_ready_o [*8];
  endproperty
  a_ready_delay: assert property (p_ready_delay)
    else $error("delay short");
  property p_enable;
    cmd_take && cmd_op_i == OP_ENABLE |->
      ##[1:3] cs_oe_o && sclk_oe_o && mosi_oe_o && cs_n_o;
  endproperty
  a_enable: assert property (p_enable) else $error("enable bad");
  c_stream: cover property ($rose(streaming_o));
  c_stall: cover property (cap_valid_o && !cap_ready_i [*4]);
  c_warn: cover property (status_valid_o && status_o == STAT_WARN_PARTIAL);
endmodule : sssm_master_monitor

// ---- bench/sssm_spi_slave.sv ----
// Behavioural mode 0 slave that answers a fixed word and logs what it hears.
`timescale 1ns/10ps
module sssm_spi_slave (
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic [4:0] width_i,
  input wire logic [15:0] resp_i,
  output logic miso_o
);
  logic [15:0] tx_q[$];
  logic [15:0] sh = 16'h0000;
  int k = 0;
  initial miso_o = 1'b0;
  always @(negedge cs_n_i)
  begin
    k = 0;
    sh = 16'h0000;
    miso_o = resp_i[width_i - 5'h01];
  end
  // Each sample is width bits, most significant first, in both directions.
  always @(posedge sclk_i)
  begin
    if (!cs_n_i)
    begin
      sh = {sh[14:0], mosi_i};
      k = k + 1;
      if (k == int'(width_i))
      begin
        tx_q.push_back(sh);
        sh = 16'h0000;
        k = 0;
      end
    end
  end
  always @(negedge sclk_i)
    if (!cs_n_i) miso_o <= resp_i[int'(width_i) - 1 - k];
  // Released line shows the inverse so a stale bit is never read as data.
  always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule : sssm_spi_slave

// ---- bench/spi_script_and_stream_master_tb_top.sv ----
// Self-checking bench of the script and stream master with a slave model.
`timescale 1ns/10ps
module spi_script_and_stream_master_tb_top;
  import sssm_pkg::*;
  logic clock_i = 0, resetn_i = 0, link_clk = 0, run = 0, c_valid = 0;
  logic s_start = 0, s_stop = 0, cap_ready = 0, hold = 0;
  logic [7:0] port = 8'h00, slot = 8'h00;
  logic [2:0] c_op = 3'h0;
  logic [15:0] c_arg = 16'h0000, conv = 16'h0002, gap = 16'h0001;
  logic [15:0] resp = 16'h0000;
  logic [31:0] s_count = 32'h0;
  logic [4:0] s_width = 5'h08, w = 5'h08;
  wire cmd_ready, status_valid, streaming, cap_valid, sclk, sclk_oe, mosi;
  wire mosi_oe, miso, cs_n, cs_oe, aux, aux_oe;
  wire [7:0] status, cap_slot;
  wire [15:0] cap_data;
  int err_total = 0, n_checks = 0, cyc = 0, n, d;
  logic [23:0] exp_cap[$];
  logic [7:0] exp_st[$];
  logic [15:0] exp_tx[$];
  always #12.5 clock_i = ~clock_i;
  initial
  begin
    #0.7;
    forever #3 link_clk = ~link_clk;
  end
  sssm_master DUT (.clock_i(clock_i), .resetn_i(resetn_i),
    .link_clk_i(link_clk), .run_i(run), .port_index_i(port),
    .cmd_valid_i(c_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(c_op),
    .cmd_arg_i(c_arg), .status_valid_o(status_valid), .status_o(status),
    .stream_start_i(s_start), .stream_stop_i(s_stop),
    .stream_count_i(s_count), .stream_width_i(s_width),
    .stream_conv_cycles_i(conv), .stream_gap_cycles_i(gap),
    .streaming_o(streaming), .cap_valid_o(cap_valid),
    .cap_ready_i(cap_ready), .cap_data_o(cap_data), .cap_slot_o(cap_slot),
    .sclk_o(sclk), .sclk_oe_o(sclk_oe), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
    .miso_i(miso), .cs_n_o(cs_n), .cs_oe_o(cs_oe), .aux_out_o(aux),
    .aux_oe_o(aux_oe));
  sssm_spi_slave SLV (.cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
    .width_i(w), .resp_i(resp), .miso_o(miso));
  function automatic logic [15:0] msk(input logic [4:0] x);
    return 16'((32'h1 << x) - 1);
  endfunction : msk
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task give_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Outputs are sampled mid-cycle, where registered values have settled.
  always @(negedge clock_i)
  begin
    if (resetn_i)
    begin
      if (cap_valid === 1'b1 && cap_ready === 1'b1)
      begin
        chk("cap", exp_cap.size() ? exp_cap.pop_front() : 'x,
          {cap_slot, cap_data});
        chk("tx", exp_tx.size() ? exp_tx.pop_front() : 'x,
          SLV.tx_q.size() ? SLV.tx_q.pop_front() : 'x);
      end
      if (status_valid === 1'b1)
        chk("status", exp_st.size() ? exp_st.pop_front() : 'x,
          status);
    end
  end
  always @(posedge clock_i)
  begin
    cap_ready <= !hold && ($urandom % 3 != 0);
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task cmd(input logic [2:0] op, input logic [15:0] arg);
    c_valid <= 1'b1;
    c_op <= op;
    c_arg <= arg;
    do @(negedge clock_i); while (cmd_ready !== 1'b1);
    @(posedge clock_i);
  endtask : cmd
  task run_script(input logic [7:0] p);
    @(posedge clock_i);
    run <= 1'b1;
    port <= p;
    @(posedge clock_i);
    run <= 1'b0;
    slot = 8'h00;
  endtask : run_script
  task xchg(input int cnt);
    int b;
    logic [15:0] s;
    logic [7:0] v;
    b = (w > 5'h08) ? 2 : 1;
    s = 16'h0000;
    cmd(OP_XCHG, 16'(cnt));
    for (int i = 0; i < cnt; i++)
    begin
      v = 8'($urandom);
      s = {s[7:0], v};
      cmd(OP_DATA, {8'h00, v});
      if ((i + 1) % b == 0)
      begin
        exp_cap.push_back({slot, resp & msk(w)});
        exp_tx.push_back(s & msk(w));
      end
    end
    if (cnt >= b) slot++;
  endtask : xchg
  task set_w(input logic [4:0] x);
    cmd(OP_WIDTH, {11'h000, x});
    w = x;
  endtask : set_w
  task end_run(input logic [7:0] st);
    exp_st.push_back(st);
    cmd(OP_END, 16'h0000);
    c_valid <= 1'b0;
    w = 5'h08;
    while (exp_st.size() || exp_cap.size()) @(posedge clock_i);
  endtask : end_run
  initial
  begin
    void'($urandom(32'h66eb781e));
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    chk("reset", 24'h80, {cs_n, cs_oe, sclk_oe, mosi_oe, aux_oe,
      streaming, cap_valid, status_valid});
    @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    resp = 16'($urandom);
    run_script(8'h00);
    cmd(OP_ENABLE, 16'h0000);
    d = 1 + $urandom % 4;
    cmd(OP_DELAY, 16'(d));
    // Valid drops so that the delay command is not taken a second time.
    c_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (cmd_ready !== 1'b1);
    chk("delay", 1, n >= d * US_CYCLES && n <= d * US_CYCLES + 3);
    @(posedge clock_i);
    xchg(1);
    set_w(5'h10);
    xchg(2);
    set_w(5'h01);
    xchg(1);
    set_w(5'h0c);
    xchg(4);
    xchg(3);
    end_run(STAT_WARN_PARTIAL);
    run_script(8'h00);
    xchg(1);
    xchg(0);
    end_run(STAT_ERR_ZERO);
    run_script(8'h00);
    cmd(3'h6, 16'h0000);
    end_run(STAT_ERR_OP);
    run_script(8'(1 + $urandom % 255));
    cmd(OP_XCHG, 16'h0001);
    cmd(OP_DATA, 16'h005a);
    end_run(STAT_ERR_PORT);
    w = 5'(1 + $urandom % 16);
    s_width <= w;
    s_count <= 32'h5;
    conv <= 16'(1 + $urandom % 4);
    gap <= 16'(1 + $urandom % 4);
    resp = 16'($urandom);
    for (int i = 0; i < 5; i++)
    begin
      exp_cap.push_back({8'h00, resp & msk(w)});
      exp_tx.push_back(16'h0000);
    end
    exp_st.push_back(STAT_OK);
    exp_st.push_back(STAT_ERR_BUSY);
    @(posedge clock_i);
    s_start <= 1'b1;
    hold <= 1'b1;
    @(posedge clock_i);
    s_start <= 1'b0;
    @(posedge clock_i);
    s_start <= 1'b1;
    @(posedge clock_i);
    s_start <= 1'b0;
    repeat (150) @(posedge clock_i);
    hold <= 1'b0;
    while (exp_cap.size()) @(posedge clock_i);
    repeat (100) @(posedge clock_i);
    exp_st.push_back(STAT_OK);
    s_stop <= 1'b1;
    @(posedge clock_i);
    s_stop <= 1'b0;
    while (exp_st.size()) @(posedge clock_i);
    @(negedge clock_i);
    chk("stream_end", 3'h0, {streaming, aux_oe, cap_valid});
    chk("tx_left", 24'h0, 24'(SLV.tx_q.size()));
    give_verdict();
  end
endmodule : spi_script_and_stream_master_tb_top
bind sssm_master sssm_master_monitor MON (.clock_i, .resetn_i,
  .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_arg_i, .status_valid_o,
  .status_o, .stream_start_i, .stream_stop_i, .streaming_o, .cap_valid_o,
  .cap_ready_i, .cap_data_o, .cap_slot_o, .cs_n_o, .cs_oe_o, .sclk_oe_o,
  .mosi_oe_o, .aux_out_o, .aux_oe_o);
